// *** rtl/eirq_top.sv ***
// module: external pin and pin-change interrupt logic with vector selection and AXI4-Lite registers
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1 - reset vector 0x0000, external pin 0x0001, pin change 0x0002
// RL2 - other sources use vectors 0x0003 through 0x0009 in listed order
// RL3 - pins are detected even when driven as outputs by the port
// RL4 - any unmasked pin-change input toggling raises a pin-change request
// RL5 - pin-change detection works without the I/O clock for wake-up; here it and WAKE_O are clocked by MCLK_I
// RL6 - enabled low-level mode requests continuously while the pin is low
// RL7 - edge detection on the external pin needs the running I/O clock
// RL8 - low-level detection works without the I/O clock for wake-up; here it and WAKE_O are clocked by MCLK_I
// RL9 - low level gone before start-up ends: wake without taking interrupt
// RL10 - two-bit sense field: low, any change, falling, rising; bits 1:0
// RL11 - external pin sampled before edge detection; pulses over one clock count
// RL12 - source holds the low level until the current instruction completes
// RL13 - external interrupt serviced only with bit 6 enable and global enable
// RL14 - pin-change interrupt serviced only with bit 5 enable and global enable
// RL15 - external flag bit 6 set by edge, cleared by vector or write one
// RL16 - external flag reads zero while low-level sensing is selected
// RL17 - pin-change flag bit 5 set by change, cleared by vector or write one
// RL18 - each pin-change mask bit enables detection of its own pin
// RL19 - reserved bits 7 and 4:0 of mask and flag registers read zero
// RL20 - simultaneous pending requests serviced lowest vector first
module eirq_top (
  input  wire logic                 MCLK_I,
  input  wire logic                 RST_I,
  input  wire logic                 EXT_IRQ_PIN_I,
  input  wire logic [5:0]           PIN_CHANGE_INPUTS_I,
  input  wire logic                 GLOBAL_IEN_I,
  input  wire logic [9:3]           INT_SRC_REQ_I,
  input  wire logic                 VEC_ACK_I,
  output logic                      REQ_VALID_O,
  output logic [3:0]                REQ_VECTOR_O,
  output logic                      WAKE_O,
  input  wire logic [3:0]           S_AXI_AWADDR_I,
  input  wire logic                 S_AXI_AWVALID_I,
  output logic                      S_AXI_AWREADY_O,
  input  wire logic [31:0]          S_AXI_WDATA_I,
  input  wire logic [3:0]           S_AXI_WSTRB_I,
  input  wire logic                 S_AXI_WVALID_I,
  output logic                      S_AXI_WREADY_O,
  output logic [1:0]                S_AXI_BRESP_O,
  output logic                      S_AXI_BVALID_O,
  input  wire logic                 S_AXI_BREADY_I,
  input  wire logic [3:0]           S_AXI_ARADDR_I,
  input  wire logic                 S_AXI_ARVALID_I,
  output logic                      S_AXI_ARREADY_O,
  output logic [31:0]               S_AXI_RDATA_O,
  output logic [1:0]                S_AXI_RRESP_O,
  output logic                      S_AXI_RVALID_O,
  input  wire logic                 S_AXI_RREADY_I
);

  // ********************************************************************
  // registers and state
  // ********************************************************************
  logic [7:0]        sys_ctrl_r;
  logic [7:0]        ien_mask_r;
  logic              ext_flag_r;
  logic              pc_flag_r;
  logic [5:0]        pc_sel_r;
  logic              ext_s1_r;
  logic              ext_s2_r;
  logic              ext_prev_r;
  logic [5:0]        pc_s1_r;
  logic [5:0]        pc_s2_r;
  logic [5:0]        pc_prev_r;
  logic              aw_got_r;
  logic              w_got_r;
  logic [3:0]        aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  eirq_pkg::eirq_req_t req_nxt;
  eirq_pkg::eirq_sense_t sense;
  logic              ext_event;
  logic              pc_event;
  logic              ext_level_req;
  logic              wr_fire;
  logic              wr_ok;
  logic              ack_ext;
  logic              ack_pc;

  // builds one 8-bit register view of the flags with reserved bits at zero
  function automatic logic [7:0] eirq_bits(input logic ext_b, input logic pc_b);
    logic [7:0] v;
    v = 8'h00;
    v[eirq_pkg::BIT_EXT] = ext_b;
    v[eirq_pkg::BIT_PC]  = pc_b;
    return v;
  endfunction

  assign sense = eirq_pkg::eirq_sense_t'(sys_ctrl_r[1:0]); // [RL10]

  // ********************************************************************
  // pin sampling
  // ********************************************************************
  // two-stage synchronisers; the port read-back path is upstream, so outputs still trigger
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ext_s1_r   <= 1'b1;
      ext_s2_r   <= 1'b1;
      ext_prev_r <= 1'b1;
      pc_s1_r    <= 6'h00;
      pc_s2_r    <= 6'h00;
      pc_prev_r  <= 6'h00;
    end else begin
      ext_s1_r   <= EXT_IRQ_PIN_I; // [RL3] [RL11]
      ext_s2_r   <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
      pc_s1_r    <= PIN_CHANGE_INPUTS_I;
      pc_s2_r    <= pc_s1_r;
      pc_prev_r  <= pc_s2_r;
    end
  end

  // edge detection needs the clock; a sampled pulse of one clock or longer is seen
  always_comb begin
    case (sense)
      eirq_pkg::EIRQ_ANY:  ext_event = ext_s2_r ^ ext_prev_r; // [RL7] [RL11]
      eirq_pkg::EIRQ_FALL: ext_event = ext_prev_r & ~ext_s2_r;
      eirq_pkg::EIRQ_RISE: ext_event = ~ext_prev_r & ext_s2_r;
      default:             ext_event = 1'b0;
    endcase
  end

  assign pc_event      = |((pc_s2_r ^ pc_prev_r) & pc_sel_r); // [RL4] [RL18]
  assign ext_level_req = (sense == eirq_pkg::EIRQ_LOW) & ~ext_s2_r; // [RL6]

  // ********************************************************************
  // wake-up path
  // ********************************************************************
  // combinational from the raw pins would glitch; registered, so the sleep controller
  // sees it one clock late; with the clock stopped the sleep logic must look at the pins
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      WAKE_O <= 1'b0;
    end else begin
      WAKE_O <= (ien_mask_r[eirq_pkg::BIT_EXT] & ext_level_req) // [RL8]
              | (ien_mask_r[eirq_pkg::BIT_PC] & pc_event);      // [RL5]
    end
  end

  // ********************************************************************
  // vector request
  // ********************************************************************
  // level request is not latched: a level gone before start-up yields no vector
  always_comb begin
    req_nxt.valid  = 1'b0;
    req_nxt.vector = eirq_pkg::VEC_RESET;
    if (GLOBAL_IEN_I) begin
      if (ien_mask_r[eirq_pkg::BIT_EXT] & (ext_flag_r | ext_level_req)) begin // [RL13] [RL9] [RL20]
        req_nxt.valid  = 1'b1;
        req_nxt.vector = eirq_pkg::VEC_EXT; // [RL1]
      end else if (ien_mask_r[eirq_pkg::BIT_PC] & pc_flag_r) begin // [RL14]
        req_nxt.valid  = 1'b1;
        req_nxt.vector = eirq_pkg::VEC_PC;
      end else begin
        for (int i = 9; i >= 3; i--) begin
          if (INT_SRC_REQ_I[i]) begin // [RL2]
            req_nxt.valid  = 1'b1;
            req_nxt.vector = i[3:0];
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      REQ_VALID_O  <= 1'b0;
      REQ_VECTOR_O <= eirq_pkg::VEC_RESET;
    end else begin
      REQ_VALID_O  <= req_nxt.valid;
      REQ_VECTOR_O <= req_nxt.vector;
    end
  end

  assign ack_ext = VEC_ACK_I & REQ_VALID_O & (REQ_VECTOR_O == eirq_pkg::VEC_EXT);
  assign ack_pc  = VEC_ACK_I & REQ_VALID_O & (REQ_VECTOR_O == eirq_pkg::VEC_PC);

  // ********************************************************************
  // flags: set wins over clear
  // ********************************************************************
  assign wr_fire = aw_got_r & w_got_r & ~S_AXI_BVALID_O;
  assign wr_ok   = wr_fire & w_strb_r[0];

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ext_flag_r <= eirq_pkg::RST_IFLAGS[eirq_pkg::BIT_EXT];
      pc_flag_r  <= eirq_pkg::RST_IFLAGS[eirq_pkg::BIT_PC];
    end else begin
      if (sense == eirq_pkg::EIRQ_LOW) begin
        ext_flag_r <= 1'b0; // [RL16]
      end else if (ext_event) begin
        ext_flag_r <= 1'b1; // [RL15]
      end else if (ack_ext | (wr_ok & (aw_addr_r == eirq_pkg::ADDR_IFLAGS) & w_data_r[eirq_pkg::BIT_EXT])) begin
        ext_flag_r <= 1'b0; // [RL15]
      end
      if (pc_event) begin
        pc_flag_r <= 1'b1; // [RL17]
      end else if (ack_pc | (wr_ok & (aw_addr_r == eirq_pkg::ADDR_IFLAGS) & w_data_r[eirq_pkg::BIT_PC])) begin
        pc_flag_r <= 1'b0; // [RL17]
      end
    end
  end

  // ********************************************************************
  // AXI4-Lite write channel
  // ********************************************************************
  // one write at a time; address and data are taken in either order
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      aw_got_r        <= 1'b0;
      w_got_r         <= 1'b0;
      aw_addr_r       <= 4'h0;
      w_data_r        <= 32'h0000_0000;
      w_strb_r        <= 4'h0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= eirq_pkg::RESP_OKAY;
    end else begin
      S_AXI_AWREADY_O <= ~aw_got_r & ~S_AXI_AWREADY_O & S_AXI_AWVALID_I;
      S_AXI_WREADY_O  <= ~w_got_r & ~S_AXI_WREADY_O & S_AXI_WVALID_I;
      if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= {S_AXI_AWADDR_I[3:2], 2'h0};
      end
      if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
        w_got_r  <= 1'b1;
        w_data_r <= S_AXI_WDATA_I;
        w_strb_r <= S_AXI_WSTRB_I;
      end
      if (wr_fire) begin
        aw_got_r       <= 1'b0;
        w_got_r        <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= eirq_pkg::RESP_OKAY;
      end else if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // control registers; only the low byte lane carries bits
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      sys_ctrl_r <= eirq_pkg::RST_SYS_CTRL;
      ien_mask_r <= eirq_pkg::RST_IEN_MASK;
      pc_sel_r   <= eirq_pkg::RST_PC_SEL[5:0];
    end else if (wr_ok) begin
      case (aw_addr_r)
        eirq_pkg::ADDR_SYS_CTRL: sys_ctrl_r <= w_data_r[7:0] & eirq_pkg::SYS_CTRL_WMASK; // [RL10]
        eirq_pkg::ADDR_IEN_MASK: ien_mask_r <= eirq_bits(w_data_r[eirq_pkg::BIT_EXT],
                                                         w_data_r[eirq_pkg::BIT_PC]); // [RL19]
        eirq_pkg::ADDR_PC_SEL:   pc_sel_r   <= w_data_r[5:0]; // [RL18]
        default:                 sys_ctrl_r <= sys_ctrl_r;
      endcase
    end
  end

  // ********************************************************************
  // AXI4-Lite read channel
  // ********************************************************************
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= eirq_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY_O <= ~S_AXI_ARREADY_O & ~S_AXI_RVALID_O & S_AXI_ARVALID_I;
      if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O  <= eirq_pkg::RESP_OKAY;
        case ({S_AXI_ARADDR_I[3:2], 2'h0})
          eirq_pkg::ADDR_SYS_CTRL: S_AXI_RDATA_O <= {24'h000000, sys_ctrl_r};
          eirq_pkg::ADDR_IEN_MASK: S_AXI_RDATA_O <= {24'h000000, ien_mask_r};
          eirq_pkg::ADDR_IFLAGS:   S_AXI_RDATA_O <= {24'h000000, eirq_bits(ext_flag_r, pc_flag_r)}; // [RL19]
          eirq_pkg::ADDR_PC_SEL:   S_AXI_RDATA_O <= {26'h0000000, pc_sel_r};
          default:                 S_AXI_RDATA_O <= 32'h0000_0000;
        endcase
      end else if (S_AXI_RVALID_O & S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence s_fall_seen;
    (sense == eirq_pkg::EIRQ_FALL) && ext_prev_r && !ext_s2_r;
  endsequence

  chk_ext_flag_set: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL15]
    s_fall_seen |=> ext_flag_r)
    else $error("falling edge did not set external flag");
  chk_low_flag_zero: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL16]
    $past(sense) == eirq_pkg::EIRQ_LOW && !$past(RST_I) |-> !ext_flag_r)
    else $error("external flag set in low-level mode");
  chk_pc_flag_set: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL4]
    pc_event |=> pc_flag_r)
    else $error("pin change did not set flag");
  chk_level_request: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL6]
    GLOBAL_IEN_I && ien_mask_r[6] && ext_level_req |=> REQ_VALID_O && REQ_VECTOR_O == 4'h1)
    else $error("low level not requesting vector one");
  chk_global_gate: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL13]
    !GLOBAL_IEN_I |=> !REQ_VALID_O)
    else $error("request without global enable");
  chk_pc_gate: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL14]
    REQ_VALID_O && REQ_VECTOR_O == 4'h2 |-> $past(ien_mask_r[5]) && $past(pc_flag_r))
    else $error("pin-change vector without enable and flag");
  chk_masked_pin: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL18]
    pc_sel_r == 6'h00 && !pc_flag_r |=> !pc_flag_r)
    else $error("masked pins set the flag");
  chk_reserved_zero: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL19]
    (ien_mask_r & 8'h9F) == 8'h00)
    else $error("reserved mask bits set");
  chk_priority_low: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL20]
    GLOBAL_IEN_I && ien_mask_r[6] && ext_flag_r |=> REQ_VECTOR_O == 4'h1)
    else $error("lower vector not served first");
  chk_write_resp: assert property (@(posedge MCLK_I) disable iff (RST_I)
    wr_fire |=> S_AXI_BVALID_O)
    else $error("write response missing");

  // wake hint and flag clear; the level request must never outlive the sampled low level
  chk_wake_pc: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL5]
    ien_mask_r[eirq_pkg::BIT_PC] && pc_event |=> WAKE_O)
    else $error("enabled pin change gave no wake hint");
  chk_wake_level: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL8]
    ien_mask_r[eirq_pkg::BIT_EXT] && ext_level_req |=> WAKE_O)
    else $error("enabled low level gave no wake hint");
  chk_ext_clear: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL15]
    ack_ext && !ext_event |=> !ext_flag_r)
    else $error("taken external vector left flag set");
  chk_level_unlatched: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RL9]
    (sense == eirq_pkg::EIRQ_LOW) && ext_s2_r && !ext_flag_r |=> REQ_VECTOR_O != eirq_pkg::VEC_EXT)
    else $error("external vector without low level");

endmodule
`default_nettype wire

// *** rtl/eirq_pkg.sv ***
// package: register map, field positions, vectors and carrier types of the external interrupt block
package eirq_pkg;

  // ********************************************************************
  // register byte addresses
  // ********************************************************************
  localparam logic [3:0] ADDR_SYS_CTRL = 4'h0;
  localparam logic [3:0] ADDR_IEN_MASK = 4'h4;
  localparam logic [3:0] ADDR_IFLAGS   = 4'h8;
  localparam logic [3:0] ADDR_PC_SEL   = 4'hC;

  // ********************************************************************
  // field positions and reset values
  // ********************************************************************
  localparam int         BIT_EXT      = 6;
  localparam int         BIT_PC       = 5;
  localparam logic [7:0] RST_SYS_CTRL = 8'h00;
  localparam logic [7:0] RST_IEN_MASK = 8'h00;
  localparam logic [7:0] RST_IFLAGS   = 8'h00;
  localparam logic [7:0] RST_PC_SEL   = 8'h00;
  localparam logic [7:0] SYS_CTRL_WMASK = 8'h7B;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ********************************************************************
  // vector words
  // ********************************************************************
  localparam logic [3:0] VEC_RESET   = 4'h0;
  localparam logic [3:0] VEC_EXT     = 4'h1;
  localparam logic [3:0] VEC_PC      = 4'h2;
  localparam logic [3:0] VEC_TOV     = 4'h3;
  localparam logic [3:0] VEC_EE      = 4'h4;
  localparam logic [3:0] VEC_ACMP    = 4'h5;
  localparam logic [3:0] VEC_CMPA    = 4'h6;
  localparam logic [3:0] VEC_CMPB    = 4'h7;
  localparam logic [3:0] VEC_WDOG    = 4'h8;
  localparam logic [3:0] VEC_ADC     = 4'h9;

  // sense modes of the external pin
  typedef enum logic [1:0] {
    EIRQ_LOW  = 2'h0,
    EIRQ_ANY  = 2'h1,
    EIRQ_FALL = 2'h2,
    EIRQ_RISE = 2'h3
  } eirq_sense_t;

  // request toward the core
  typedef struct packed {
    logic       valid;
    logic [3:0] vector;
  } eirq_req_t;

endpackage

// *** dv/eirq_core_model.sv ***
// partner model: processor core that takes the presented interrupt vector
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// core acknowledge model
// ********************************************************************
module eirq_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       active_i,
  input  wire logic       slow_i,
  input  wire logic       req_valid_i,
  input  wire logic [3:0] req_vector_i,
  output logic            ack_o,
  output logic            taken_o,
  output logic [3:0]      taken_vec_o
);
  logic [3:0] gap_r;

  // one ack per request, then a quiet gap: the registered request lags the flag clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o       <= 1'b0;
      taken_o     <= 1'b0;
      taken_vec_o <= 4'h0;
      gap_r       <= 4'h0;
    end else begin
      ack_o   <= 1'b0;
      taken_o <= 1'b0;
      if (gap_r != 4'h0) begin
        gap_r <= gap_r - 4'h1;
      end else if (active_i && req_valid_i) begin
        ack_o       <= 1'b1;
        taken_o     <= 1'b1;
        taken_vec_o <= req_vector_i;
        gap_r       <= slow_i ? 4'h8 : 4'h3; // slow core stays in the handler longer
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/eirq_test.sv ***
// testbench: external pin, pin-change and vector request checks of the interrupt block
`timescale 1ns/1ps
`default_nettype none
module eirq_test;
  logic        mclk, rst, ext_pin, gie, ack, taken, core_on, core_slow, req_valid, wake;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [5:0]  pc_pins;
  logic [9:3]  src_req;
  logic [3:0]  taken_vec, req_vec, awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  vq[$];
  logic [31:0] rq[$];
  int          miscompares, checks_done, p, m;
  integer      seed;
  logic [3:0]  regs[4] = '{eirq_pkg::ADDR_SYS_CTRL, eirq_pkg::ADDR_IEN_MASK, eirq_pkg::ADDR_IFLAGS,
                           eirq_pkg::ADDR_PC_SEL};

  eirq_top i_dut (.MCLK_I(mclk), .RST_I(rst), .EXT_IRQ_PIN_I(ext_pin), .PIN_CHANGE_INPUTS_I(pc_pins),
    .GLOBAL_IEN_I(gie), .INT_SRC_REQ_I(src_req), .VEC_ACK_I(ack), .REQ_VALID_O(req_valid),
    .REQ_VECTOR_O(req_vec), .WAKE_O(wake), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));

  eirq_core_model i_core (.clk_i(mclk), .rst_i(rst), .active_i(core_on), .slow_i(core_slow),
    .req_valid_i(req_valid), .req_vector_i(req_vec), .ack_o(ack), .taken_o(taken), .taken_vec_o(taken_vec));

  // ********************************************************************
  // helpers
  // ********************************************************************
  always #20 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // address and data offered together, each dropped at its own handshake
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // expected data goes to the queue; the monitor compares when the data shows
  task automatic axi_rd(input logic [3:0] a, input logic [7:0] exp);
    rq.push_back({24'h000000, exp});
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // monitor: oldest note is matched against each taken vector and each read
  always @(posedge mclk) begin
    if (taken === 1'b1)
      chk(32'(taken_vec), 32'(vq.size() > 0 ? vq.pop_front() : 4'hF), "vector");
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk(rdata, rq.pop_front(), "read data");
      chk(32'(rresp), 32'(eirq_pkg::RESP_OKAY), "read resp");
    end
    if (bvalid === 1'b1 && bready === 1'b1)
      chk(32'(bresp), 32'(eirq_pkg::RESP_OKAY), "write resp");
  end

  // watchdog: the whole sequence needs well under this span
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    summarize();
  end

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    mclk = 1'b0;
    {rst, ext_pin, gie, core_on, core_slow, pc_pins, src_req} = {1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 6'h00, 7'h00};
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wstrb, wdata} = '0;
    seed = 32'h2998;
    wt(6);
    rst <= 1'b0;
    wstrb <= 4'hF;
    foreach (regs[i]) axi_rd(regs[i], 8'h00);
    axi_rd(4'h2, 8'h00);
    axi_wr(eirq_pkg::ADDR_SYS_CTRL, 8'hFF);
    axi_rd(eirq_pkg::ADDR_SYS_CTRL, eirq_pkg::SYS_CTRL_WMASK);
    // a write with the low byte lane off must leave the register alone
    wstrb <= 4'h0;
    axi_wr(eirq_pkg::ADDR_SYS_CTRL, 8'h00);
    axi_rd(eirq_pkg::ADDR_SYS_CTRL, eirq_pkg::SYS_CTRL_WMASK);
    wstrb <= 4'hF;
    axi_wr(eirq_pkg::ADDR_IEN_MASK, 8'hFF);
    axi_rd(eirq_pkg::ADDR_IEN_MASK, 8'h60);
    axi_wr(eirq_pkg::ADDR_PC_SEL, 8'hFF);
    axi_rd(eirq_pkg::ADDR_PC_SEL, 8'h3F);
    axi_wr(eirq_pkg::ADDR_IFLAGS, 8'hFF);
    axi_rd(eirq_pkg::ADDR_IFLAGS, 8'h00);
    $display("test registers done");
    p = $unsigned($random(seed)) % 6;
    axi_wr(eirq_pkg::ADDR_PC_SEL, 8'(1 << p));
    axi_wr(eirq_pkg::ADDR_IEN_MASK, 8'h20);
    pc_pins <= pc_pins ^ 6'(1 << ((p + 1) % 6));
    wt(8);
    axi_rd(eirq_pkg::ADDR_IFLAGS, 8'h00);
    pc_pins <= pc_pins ^ 6'(1 << p);
    wt(8);
    axi_rd(eirq_pkg::ADDR_IFLAGS, 8'h20);
    axi_wr(eirq_pkg::ADDR_IFLAGS, 8'h20);
    axi_rd(eirq_pkg::ADDR_IFLAGS, 8'h00);
    vq.push_back(eirq_pkg::VEC_PC);
    gie <= 1'b1;
    pc_pins <= pc_pins ^ 6'(1 << p);
    wt(12);
    $display("test pin change done");
    axi_wr(eirq_pkg::ADDR_IEN_MASK, 8'h40);
    for (m = 1; m < 4; m++) begin
      axi_wr(eirq_pkg::ADDR_SYS_CTRL, 8'(m));
      repeat (m == 1 ? 2 : 1) vq.push_back(eirq_pkg::VEC_EXT);
      ext_pin <= 1'b0;
      wt(m == 1 ? 10 : 2);
      ext_pin <= 1'b1;
      wt(12);
    end
    $display("test sense modes done");
    core_on <= 1'b0;
    gie <= 1'b0;
    axi_wr(eirq_pkg::ADDR_SYS_CTRL, 8'h00);
    ext_pin <= 1'b0;
    wt(6);
    axi_rd(eirq_pkg::ADDR_IFLAGS, 8'h00);
    chk(32'(wake), 32'h1, "wake on low level");
    gie <= 1'b1;
    wt(4);
    repeat (20) begin
      wt(1);
      chk(32'({req_valid, req_vec}), 32'h11, "low level request");
    end
    ext_pin <= 1'b1;
    wt(6);
    chk(32'(req_valid), 32'h0, "request after release");
    for (m = 3; m < 10; m++) begin
      src_req <= 7'(1 << (m - 3));
      wt(4);
      chk(32'({req_valid, req_vec}), 32'(16 + m), "internal vector");
    end
    src_req <= 7'h7F;
    wt(4);
    chk(32'(req_vec), 32'(eirq_pkg::VEC_TOV), "lowest internal first");
    src_req <= 7'h00;
    $display("test level and internal done");
    gie <= 1'b0;
    axi_wr(eirq_pkg::ADDR_SYS_CTRL, 8'h02);
    axi_wr(eirq_pkg::ADDR_IEN_MASK, 8'h60);
    axi_wr(eirq_pkg::ADDR_PC_SEL, 8'h3F);
    ext_pin <= 1'b0;
    pc_pins <= ~pc_pins;
    wt(3);
    ext_pin <= 1'b1;
    wt(8);
    axi_rd(eirq_pkg::ADDR_IFLAGS, 8'h60);
    vq.push_back(eirq_pkg::VEC_EXT);
    vq.push_back(eirq_pkg::VEC_PC);
    core_slow <= 1'b1;
    core_on <= 1'b1;
    gie <= 1'b1;
    wt(30);
    $display("test priority done");
    chk(32'(vq.size() + rq.size()), 32'h0, "notes left over");
    summarize();
  end

endmodule
`default_nettype wire
